// *** src/spis_pkg.sv ***
// spis_pkg: constants shared by the port interrupt status block.
// assumes a plain register port with byte addresses as offsets.
package spis_pkg;
	// register byte addresses (chosen; no offsets printed)
	localparam logic [7:0] SPIS_ADDR_STATUS = 8'h10;
	localparam logic [7:0] SPIS_ADDR_ENABLE = 8'h14;
	localparam logic [7:0] SPIS_ADDR_DIAG = 8'h30;
	localparam logic [7:0] SPIS_ADDR_CTRL = 8'h40;
	// status bit positions
	localparam int SPIS_BIT_OVERFLOW = 24;
	localparam int SPIS_BIT_WRONG_PM = 23;
	localparam int SPIS_BIT_PHY_RDY = 22;
	localparam int SPIS_BIT_MECH = 7;
	localparam int SPIS_BIT_CONNECT = 6;
	localparam int SPIS_BIT_DESC = 5;
	localparam int SPIS_BIT_UNKNOWN = 4;
	localparam int SPIS_BIT_SDB = 3;
	localparam int SPIS_BIT_DMA = 2;
	localparam int SPIS_BIT_PIO = 1;
	localparam int SPIS_BIT_D2H = 0;
	// diagnostic bit positions in the diag register (port error word)
	localparam int SPIS_DIAG_N = 16;
	localparam int SPIS_DIAG_F = 25;
	localparam int SPIS_DIAG_X = 26;
	// control register bit positions
	localparam int SPIS_CTRL_GIE = 0;
	localparam int SPIS_CTRL_CAP_MECH = 1;
	localparam int SPIS_CTRL_PORT_MECH = 2;
	// writable and implemented masks; bits 21:8 and 31:25 reserved
	localparam logic [31:0] SPIS_W1C_MASK = 32'h0180_00AF;
	localparam logic [31:0] SPIS_IMPL_MASK = 32'h01C0_00FF;
	localparam logic [31:0] SPIS_DIAG_MASK = 32'h0601_0000;
	localparam logic [31:0] SPIS_RESET_VAL = 32'h0000_0000;
	// pio setup event waits for its data transfer to finish
	typedef enum logic [0:0] {SPIS_PIO_IDLE, SPIS_PIO_WAIT} spis_pio_t;
endpackage : spis_pkg

// *** src/spis_sync.sv ***
// spis_sync: two-flop synchroniser for a level from outside the clock domain.
// assumes the input may change at any time.
`timescale 1ns/1ps
module spis_sync (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_q;
	// first stage feeds only the second
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : spis_sync

// *** src/spis_top.sv ***
// spis_top: lower half of a port interrupt status register with its
// enable, diagnostic mirror bits and interrupt output.
// assumes event pulses come from same-clock receive/transfer logic and
// the mechanical switch arrives asynchronously from a pin.
//
// Overview of operation
// - overflow bit 24 set on too many received bytes; write one clears.
// - bit 23 set on frame from drive without outstanding command; write one clears.
// - no bit 23 for set-device-bits frame with notification bit one.
// - bit 22 is read-only and mirrors the phy-ready-change diagnostic bit.
// - bit 7 set when mechanical switch opens or closes; write one clears.
// - bit 7 valid only when both switch capability bits are one.
// - bit 6 read-only, mirrors exchange diagnostic bit, clears with it.
// - bit 5 set when interrupting descriptor finishes its data; write one clears.
// - unknown-frame diagnostic bit set at detection, before memory write.
// - bit 4 set only after the unknown frame reaches memory.
// - clearing unknown-frame diagnostic bit clears bit 4.
// - bit 3 set on stored set-device-bits frame with interrupt bit.
// - bit 2 set on stored dma-setup frame with interrupt bit.
// - bit 1 set after pio-setup frame stored and its data transfer done.
// - bit 1 set even when that data transfer ended in error.
// - bit 0 set on stored device-to-host register frame with interrupt bit.
// - interrupt when status bit, its enable and global enable are all set.
// - status recorded even with its enable bit zero.
`timescale 1ns/1ps
module spis_top import spis_pkg::*; (
	input wire logic clock,
	input wire logic reset_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	// events from receive and transfer logic
	input wire logic overflow_event,
	input wire logic frame_no_cmd_event,
	input wire logic frame_is_sdb_notify,
	input wire logic phy_ready_signal,
	input wire logic connect_change_event,
	input wire logic mech_switch_pin,
	input wire logic descriptor_done_event,
	input wire logic unknown_frame_detect,
	input wire logic unknown_frame_stored,
	input wire logic sdb_stored_event,
	input wire logic dma_setup_stored_event,
	input wire logic pio_setup_stored_event,
	input wire logic pio_data_done_event,
	input wire logic d2h_stored_event,
	// interrupt
	output logic irq
);
	logic [31:0] enable_q;
	logic [31:0] rdata_d;
	logic [31:0] status_word;
	logic [31:0] w1c_set;
	logic [31:0] w1c_clr;
	logic [31:0] w1c_flags;
	logic diag_phy_ready_change;
	logic diag_exchange;
	logic diag_unknown_frame;
	logic unknown_frame_flag;
	logic gie_q;
	logic cap_mech_switch_support;
	logic port_mech_switch_present;
	logic mech_sync;
	logic mech_prev_q;
	logic [1:0] mech_warm_q;
	logic mech_armed_q;
	logic mech_change;
	logic phy_prev_q;
	logic phy_ready_change_event;
	logic diag_write;
	spis_pio_t pio_state_q;
	logic pio_done_pulse;

	// register write decode, one function for every address match
	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] target);
		reg_hit = (addr == target);
	endfunction : reg_hit

	assign diag_write = reg_write && reg_hit(reg_addr, SPIS_ADDR_DIAG);

	// mechanical switch is a pin, so it is synchronised first
	spis_sync u_mech_sync (
		.clock(clock),
		.reset_n(reset_n),
		.async_in(mech_switch_pin),
		.sync_out(mech_sync)
	);

	// phy ready history, same clock so no synchroniser
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			phy_prev_q <= 1'b0;
		end else begin
			phy_prev_q <= phy_ready_signal;
		end
	end

	// switch history; the pin level at reset is unknown, not a change
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mech_prev_q <= 1'b0;
		end else begin
			mech_prev_q <= mech_sync;
		end
	end

	// arming: history holds a real pin level only once the synchroniser
	// has filled and one more edge has copied it, so no false edge after reset
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mech_warm_q <= 2'b00;
			mech_armed_q <= 1'b0;
		end else begin
			mech_warm_q <= {mech_warm_q[0], 1'b1};
			mech_armed_q <= mech_warm_q[1];
		end
	end

	// a switch edge only counts once the history is armed
	assign mech_change = mech_armed_q && (mech_sync ^ mech_prev_q);

	// phy ready is same-clock; first cycle after reset may flag a change
	assign phy_ready_change_event = phy_ready_signal ^ phy_prev_q;

	// control: global interrupt enable from software
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			gie_q <= 1'b0;
		end else if (reg_write && reg_hit(reg_addr, SPIS_ADDR_CTRL)) begin
			gie_q <= reg_wdata[SPIS_CTRL_GIE];
		end
	end

	// control: switch capability straps, both needed for bit 7
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cap_mech_switch_support <= 1'b0;
			port_mech_switch_present <= 1'b0;
		end else if (reg_write && reg_hit(reg_addr, SPIS_ADDR_CTRL)) begin
			cap_mech_switch_support <= reg_wdata[SPIS_CTRL_CAP_MECH];
			port_mech_switch_present <= reg_wdata[SPIS_CTRL_PORT_MECH];
		end
	end

	// enable register; only implemented bits are writable
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			enable_q <= SPIS_RESET_VAL;
		end else if (reg_write && reg_hit(reg_addr, SPIS_ADDR_ENABLE)) begin
			enable_q <= reg_wdata & SPIS_IMPL_MASK;
		end
	end

	// phy-ready-change diagnostic, write one clears, set wins
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			diag_phy_ready_change <= 1'b0;
		end else if (phy_ready_change_event) begin
			diag_phy_ready_change <= 1'b1;
		end else if (diag_write && reg_wdata[SPIS_DIAG_N]) begin
			diag_phy_ready_change <= 1'b0;
		end
	end

	// exchange diagnostic, seen as the connect change flag
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			diag_exchange <= 1'b0;
		end else if (connect_change_event) begin
			diag_exchange <= 1'b1;
		end else if (diag_write && reg_wdata[SPIS_DIAG_X]) begin
			diag_exchange <= 1'b0;
		end
	end

	// unknown-frame diagnostic, raised at detection before the store
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			diag_unknown_frame <= 1'b0;
		end else if (unknown_frame_detect) begin
			diag_unknown_frame <= 1'b1;
		end else if (diag_write && reg_wdata[SPIS_DIAG_F]) begin
			diag_unknown_frame <= 1'b0;
		end
	end

	// unknown-frame status: set on store, cleared only with its diag bit
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			unknown_frame_flag <= 1'b0;
		end else if (unknown_frame_stored) begin
			unknown_frame_flag <= 1'b1;
		end else if (diag_write && reg_wdata[SPIS_DIAG_F]) begin
			unknown_frame_flag <= 1'b0;
		end
	end

	// pio setup waits for data phase end, error or not
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pio_state_q <= SPIS_PIO_IDLE;
		end else begin
			unique case (pio_state_q)
				SPIS_PIO_IDLE: begin
					if (pio_setup_stored_event && !pio_data_done_event) begin
						pio_state_q <= SPIS_PIO_WAIT;
					end
				end
				SPIS_PIO_WAIT: begin
					if (pio_data_done_event) begin
						pio_state_q <= SPIS_PIO_IDLE;
					end
				end
			endcase
		end
	end

	assign pio_done_pulse = pio_data_done_event &&
		(pio_state_q == SPIS_PIO_WAIT || pio_setup_stored_event);

	// hardware set sources for the sticky bits
	always_comb begin
		w1c_set = 32'h0000_0000;
		w1c_set[SPIS_BIT_OVERFLOW] = overflow_event;
		w1c_set[SPIS_BIT_WRONG_PM] = frame_no_cmd_event && !frame_is_sdb_notify;
		w1c_set[SPIS_BIT_MECH] = mech_change &&
			cap_mech_switch_support && port_mech_switch_present;
		w1c_set[SPIS_BIT_DESC] = descriptor_done_event;
		w1c_set[SPIS_BIT_SDB] = sdb_stored_event;
		w1c_set[SPIS_BIT_DMA] = dma_setup_stored_event;
		w1c_set[SPIS_BIT_PIO] = pio_done_pulse;
		w1c_set[SPIS_BIT_D2H] = d2h_stored_event;
	end

	// write one clears, only on the status address and writable bits
	assign w1c_clr = (reg_write && reg_hit(reg_addr, SPIS_ADDR_STATUS)) ?
		(reg_wdata & SPIS_W1C_MASK) : 32'h0000_0000;

	// one sticky cell per writable bit; others tie to zero
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_flag
			if (SPIS_W1C_MASK[gi]) begin : g_w1c
				spis_w1c_bit u_bit (
					.clock(clock),
					.reset_n(reset_n),
					.set_pulse(w1c_set[gi]),
					.clear_pulse(w1c_clr[gi]),
					.flag_q(w1c_flags[gi])
				);
			end else begin : g_none
				assign w1c_flags[gi] = 1'b0;
			end
		end
	endgenerate

	// assemble the status word; mirrors are read-only, reserved read zero
	always_comb begin
		status_word = w1c_flags;
		status_word[SPIS_BIT_PHY_RDY] = diag_phy_ready_change;
		status_word[SPIS_BIT_CONNECT] = diag_exchange;
		status_word[SPIS_BIT_UNKNOWN] = unknown_frame_flag;
	end

	// read mux, data in the cycle after the strobe
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (reg_hit(reg_addr, SPIS_ADDR_STATUS)) begin
			rdata_d = status_word & SPIS_IMPL_MASK;
		end else if (reg_hit(reg_addr, SPIS_ADDR_ENABLE)) begin
			rdata_d = enable_q;
		end else if (reg_hit(reg_addr, SPIS_ADDR_DIAG)) begin
			rdata_d[SPIS_DIAG_N] = diag_phy_ready_change;
			rdata_d[SPIS_DIAG_F] = diag_unknown_frame;
			rdata_d[SPIS_DIAG_X] = diag_exchange;
		end else if (reg_hit(reg_addr, SPIS_ADDR_CTRL)) begin
			rdata_d[SPIS_CTRL_GIE] = gie_q;
			rdata_d[SPIS_CTRL_CAP_MECH] = cap_mech_switch_support;
			rdata_d[SPIS_CTRL_PORT_MECH] = port_mech_switch_present;
		end
	end

	// read data register; holds zero when no read is taken
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_read) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// interrupt output registered to keep it glitch-free
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= gie_q && |(status_word & enable_q);
		end
	end
endmodule : spis_top

// *** src/spis_w1c_bit.sv ***
// spis_w1c_bit: one sticky flag, set by hardware, cleared by a written one.
// assumes set and clear are single-cycle pulses on the block clock.
`timescale 1ns/1ps
module spis_w1c_bit import spis_pkg::*; (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic set_pulse,
	input wire logic clear_pulse,
	output logic flag_q
);
	// set beats clear so a same-cycle event is not lost
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			flag_q <= 1'b0;
		end else if (set_pulse) begin
			flag_q <= 1'b1;
		end else if (clear_pulse) begin
			flag_q <= 1'b0;
		end
	end
endmodule : spis_w1c_bit

// *** testbench/spis_evsrc.sv ***
// spis_evsrc: stand-in for the port's receive and transfer logic.
// assumes one request vector from the bench, high for one cycle.
`timescale 1ns/1ps
module spis_evsrc (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [13:0] ev,
	output logic [13:0] ev_o,
	output logic phy_ready,
	output logic mech_pin
);
	logic mech_q = 1'b0;
	// pulses pass straight through; ordering is left to the bench
	assign ev_o = ev;
	// link level flips on request, like a cable pull
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			phy_ready <= 1'b0;
		end else begin
			phy_ready <= phy_ready ^ ev[10];
		end
	end
	// the switch is mechanical, so a chip reset leaves its level alone
	always @(posedge clock) begin
		mech_q <= mech_q ^ ev[8];
	end
	assign mech_pin = mech_q;
endmodule : spis_evsrc

// *** testbench/spis_top_properties.sv ***
// spis_top_properties: port-level checks for the status block.
// assumes it is bound to spis_top; one clock domain.
`timescale 1ns/1ps
module spis_chk import spis_pkg::*; (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic overflow_event,
	input wire logic frame_no_cmd_event,
	input wire logic frame_is_sdb_notify,
	input wire logic descriptor_done_event,
	input wire logic sdb_stored_event,
	input wire logic pio_setup_stored_event,
	input wire logic pio_data_done_event,
	input wire logic d2h_stored_event
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	// status strobes; reads one cycle after an event see the new bit
	logic st_rd;
	logic st_wr;
	assign st_rd = reg_read && reg_addr == SPIS_ADDR_STATUS;
	assign st_wr = reg_write && reg_addr == SPIS_ADDR_STATUS;
	read_quiet_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside read slot");
	rsvd_zero_a: assert property (st_rd |=> reg_rdata[21:8] == 14'h0)
		else $error("reserved status bits not zero");
	ovf_set_a: assert property (overflow_event ##1 st_rd |=> reg_rdata[24])
		else $error("overflow bit not set");
	wrong_pm_a: assert property (frame_no_cmd_event && !frame_is_sdb_notify ##1 st_rd
		|=> reg_rdata[23])
		else $error("wrong multiplier bit not set");
	desc_set_a: assert property (descriptor_done_event ##1 st_rd |=> reg_rdata[5])
		else $error("descriptor bit not set");
	sdb_set_a: assert property (sdb_stored_event ##1 st_rd |=> reg_rdata[3])
		else $error("set device bits flag not set");
	pio_set_a: assert property (pio_setup_stored_event && pio_data_done_event ##1 st_rd
		|=> reg_rdata[1])
		else $error("pio setup flag not set");
	set_wins_a: assert property (d2h_stored_event && st_wr && reg_wdata[0] ##1 st_rd
		|=> reg_rdata[0])
		else $error("clear beat a hardware set");
	cover property (st_rd ##1 reg_rdata[0]);
	cover property (st_rd ##1 reg_rdata[4]);
	cover property (st_rd ##1 reg_rdata[7]);
endmodule : spis_chk

bind spis_top spis_chk i_chk (.clock, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
	.reg_rdata, .overflow_event, .frame_no_cmd_event, .frame_is_sdb_notify, .descriptor_done_event,
	.sdb_stored_event, .pio_setup_stored_event, .pio_data_done_event, .d2h_stored_event);

// *** testbench/testbench.sv ***
// testbench: drives the status block through its register port and events.
// assumes spis_top, spis_evsrc and the bound checker are compiled first.
`timescale 1ns/1ps
module testbench import spis_pkg::*;;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [13:0] ev = 14'h0;
	logic [31:0] reg_rdata;
	logic [13:0] ev_o;
	logic phy_ready;
	logic mech_pin;
	logic irq;
	int mismatches = 0;
	int tests_run = 0;
	// 100 ns clock
	initial begin
		forever #50 clock = ~clock;
	end
	spis_evsrc i_src (.clock, .reset_n, .ev, .ev_o, .phy_ready, .mech_pin);
	spis_top i_dut (.clock, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
		.overflow_event(ev_o[13]), .frame_no_cmd_event(ev_o[12]), .frame_is_sdb_notify(ev_o[11]),
		.phy_ready_signal(phy_ready), .connect_change_event(ev_o[9]), .mech_switch_pin(mech_pin),
		.descriptor_done_event(ev_o[7]), .unknown_frame_detect(ev_o[6]),
		.unknown_frame_stored(ev_o[5]), .sdb_stored_event(ev_o[4]), .dma_setup_stored_event(ev_o[3]),
		.pio_setup_stored_event(ev_o[2]), .pio_data_done_event(ev_o[1]), .d2h_stored_event(ev_o[0]),
		.irq);
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wr
	// data stand only in the cycle after the strobe
	task automatic rd(logic [7:0] a, logic [31:0] e, string n);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 chk(n, e, reg_rdata);
	endtask : rd
	task automatic pulse(logic [13:0] v);
		@(posedge clock);
		ev <= v;
		@(posedge clock);
		ev <= 14'h0;
	endtask : pulse
	// event, optional same-cycle clear, then status read the very next cycle
	task automatic fire_rd(logic [13:0] v, logic [31:0] c, logic [31:0] e, string n);
		@(posedge clock);
		ev <= v;
		reg_write <= |c;
		reg_addr <= SPIS_ADDR_STATUS;
		reg_wdata <= c;
		@(posedge clock);
		ev <= 14'h0;
		reg_write <= 1'b0;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 chk(n, e, reg_rdata);
	endtask : fire_rd
	task automatic t_reset;
		rd(SPIS_ADDR_STATUS, 32'h0, "status");
		rd(SPIS_ADDR_ENABLE, 32'h0, "enable");
		rd(SPIS_ADDR_CTRL, 32'h0, "ctrl");
		wr(8'h04, 32'hFFFF_FFFF);
		rd(8'h04, 32'h0, "unmapped");
	endtask : t_reset
	// enables stay zero here, so recording must not depend on them
	task automatic t_w1c;
		logic [13:0] evs [6] = '{14'h2000, 14'h1000, 14'h0080, 14'h0010, 14'h0008, 14'h0001};
		int bits [6] = '{24, 23, 5, 3, 2, 0};
		foreach (evs[i]) begin
			fire_rd(evs[i], 32'h0, 32'h1 << bits[i], "set");
			wr(SPIS_ADDR_STATUS, ~(32'h1 << bits[i]));
			rd(SPIS_ADDR_STATUS, 32'h1 << bits[i], "keep");
			wr(SPIS_ADDR_STATUS, 32'h1 << bits[i]);
			rd(SPIS_ADDR_STATUS, 32'h0, "clear");
		end
	endtask : t_w1c
	task automatic t_race;
		fire_rd(14'h1800, 32'h0, 32'h0, "notify");
		fire_rd(14'h0001, 32'h1, 32'h1, "set_wins");
		wr(SPIS_ADDR_STATUS, 32'h1);
	endtask : t_race
	// detect must come before the store, as on a real link
	task automatic t_unknown;
		fire_rd(14'h0040, 32'h0, 32'h0, "unk_detect");
		rd(SPIS_ADDR_DIAG, 32'h1 << SPIS_DIAG_F, "diag_f");
		fire_rd(14'h0020, 32'h0, 32'h10, "unk_stored");
		wr(SPIS_ADDR_STATUS, 32'h10);
		rd(SPIS_ADDR_STATUS, 32'h10, "unk_ro");
		wr(SPIS_ADDR_DIAG, 32'h1 << SPIS_DIAG_F);
		rd(SPIS_ADDR_STATUS, 32'h0, "unk_clr");
	endtask : t_unknown
	task automatic t_mirror;
		pulse(14'h0600);
		repeat (2) @(posedge clock);
		rd(SPIS_ADDR_STATUS, 32'h0040_0040, "mirror");
		wr(SPIS_ADDR_STATUS, 32'h0040_0040);
		rd(SPIS_ADDR_STATUS, 32'h0040_0040, "mirror_ro");
		wr(SPIS_ADDR_DIAG, 32'h0401_0000);
		rd(SPIS_ADDR_STATUS, 32'h0, "mirror_clr");
	endtask : t_mirror
	// synchroniser adds latency, so wait past it
	task automatic t_mech;
		pulse(14'h0100);
		repeat (5) @(posedge clock);
		rd(SPIS_ADDR_STATUS, 32'h0, "mech_off");
		wr(SPIS_ADDR_CTRL, 32'h6);
		pulse(14'h0100);
		repeat (5) @(posedge clock);
		rd(SPIS_ADDR_STATUS, 32'h80, "mech_on");
		wr(SPIS_ADDR_STATUS, 32'h80);
		rd(SPIS_ADDR_STATUS, 32'h0, "mech_clr");
	endtask : t_mech
	// switch left closed across a reset must not read as a change
	task automatic t_rst_mid;
		pulse(14'h0100);
		@(posedge clock);
		reset_n <= 1'b0;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		wr(SPIS_ADDR_CTRL, 32'h6);
		repeat (5) @(posedge clock);
		rd(SPIS_ADDR_STATUS, 32'h0, "mech_rst");
		pulse(14'h0100);
		repeat (5) @(posedge clock);
		rd(SPIS_ADDR_STATUS, 32'h80, "mech_after");
		wr(SPIS_ADDR_STATUS, 32'h80);
		wr(SPIS_ADDR_CTRL, 32'h0);
	endtask : t_rst_mid
	task automatic t_pio;
		fire_rd(14'h0002, 32'h0, 32'h0, "pio_early");
		fire_rd(14'h0004, 32'h0, 32'h0, "pio_armed");
		fire_rd(14'h0002, 32'h0, 32'h2, "pio_done");
		wr(SPIS_ADDR_STATUS, 32'h2);
		fire_rd(14'h0006, 32'h0, 32'h2, "pio_same");
		wr(SPIS_ADDR_STATUS, 32'h2);
	endtask : t_pio
	task automatic t_irq;
		wr(SPIS_ADDR_ENABLE, 32'h1);
		wr(SPIS_ADDR_CTRL, 32'h1);
		fire_rd(14'h0001, 32'h0, 32'h1, "d2h");
		chk("irq_on", 32'h1, {31'h0, irq});
		wr(SPIS_ADDR_CTRL, 32'h0);
		@(posedge clock);
		#1 chk("irq_masked", 32'h0, {31'h0, irq});
		wr(SPIS_ADDR_CTRL, 32'h1);
		wr(SPIS_ADDR_ENABLE, 32'h2);
		@(posedge clock);
		#1 chk("irq_enable", 32'h0, {31'h0, irq});
		wr(SPIS_ADDR_STATUS, 32'h1);
	endtask : t_irq
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		t_reset();
		t_w1c();
		t_race();
		t_unknown();
		t_mirror();
		t_mech();
		t_rst_mid();
		t_pio();
		t_irq();
		stop_test();
	end
	// watchdog: the tests need well under 1000 cycles
	initial begin
		#(3000 * 100);
		mismatches++;
		stop_test();
	end
endmodule : testbench
